// >>> hdl/otalarm_pkg.sv
// package: constants and carrier types for the over-temperature alarm and pec block
package otalarm_pkg;
    // ==========================================================
    // configuration word layout and power-on default
    localparam int CFG_W = 16;
    localparam logic [15:0] CFG_POR = 16'h0040;
    localparam int B_FLAG = 15;
    localparam int B_FQ_HI = 12;
    localparam int B_FQ_LO = 11;
    localparam int B_MODE = 9;
    localparam int B_SHDN = 8;
    localparam int B_FMT = 7;
    localparam int B_RES_HI = 6;
    localparam int B_RES_LO = 5;
    localparam int B_TMO = 4;
    localparam int B_PEC = 3;
    localparam int B_RATE_HI = 2;
    localparam int B_RATE_LO = 1;
    localparam int B_ONESHOT = 0;
    // bits software may change; the flag is excluded
    localparam logic [15:0] CFG_WMASK = 16'h1BFF;
    localparam logic [15:0] OVER_POR = 16'h5000;
    localparam logic [15:0] HYST_POR = 16'h4B00;
    // ==========================================================
    // bus address: fixed prefix plus factory selection
    localparam logic [3:0] ADDR_PREFIX = 4'h9;
    localparam logic [7:0] CRC_POLY = 8'h07;
    // ==========================================================
    // timing at 200 MHz
    localparam int CLK_MHZ = 200;
    localparam int CONV10_MS = 35;
    localparam longint CONV10_CYC = longint'(CONV10_MS) * 1000 * CLK_MHZ;
    localparam longint PERIOD4S_CYC = longint'(4000) * 1000 * CLK_MHZ;
    // fault queue depths for codes 00..11
    localparam logic [2:0] FQ_N0 = 3'h1;
    localparam logic [2:0] FQ_N1 = 3'h2;
    localparam logic [2:0] FQ_N2 = 3'h4;
    localparam logic [2:0] FQ_N3 = 3'h6;

    // register write strobe from the serial front end
    typedef struct packed {
        logic cfg_we;
        logic over_we;
        logic hyst_we;
        logic [15:0] wdata;
    } reg_wr_t;
    // conversion handshake with the analogue side
    typedef struct packed {
        logic done;
        logic [15:0] value;
    } conv_res_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_WAIT = 3'b100
    } conv_st_t;
    typedef enum logic [1:0] {
        ARM_ABOVE = 2'b01,
        ARM_BELOW = 2'b10
    } arm_t;
endpackage

// >>> hdl/otalarm_pec.sv
// over-temperature alarm, conversion scheduler and pec crc engine
// ==========================================================
// Overview of operation
// - flag sits in config bit 15, read only, host writes ignored
// - comparator mode sets flag above over threshold after fault count
// - comparator mode clears below hysteresis or on shutdown entry
// - interrupt mode sets flag when over threshold exceeded
// - interrupt mode flag holds until any register read, then clears
// - after read clear, interrupt mode rearms on opposite crossing, alternating
// - shutdown entry also clears flag in interrupt mode
// - mode change alone never clears flag
// - config powers up to fixed default word
// - pec enable bit 3 appends error byte to each message
// - crc-8 covers every message byte including address byte
// - device appends pec after reads, master after writes
// - conversion 35ms at 10 bits (code 10), half per code below, four times at code 11
// - conversion overrunning its slot is dropped, last result kept
// - bus address 1001 plus three factory bits
// - fault count codes give 1, 2, 4, 6 consecutive faults
// - hysteresis above over threshold treated as equal
// - shutdown waits for running conversion; registers stay accessible
`timescale 1ns/1ps
module otalarm_pec #(
    parameter longint CONV10_CYCLES = otalarm_pkg::CONV10_CYC,
    parameter longint PERIOD4S_CYCLES = otalarm_pkg::PERIOD4S_CYC,
    parameter logic [2:0] ADDR_SEL = 3'h0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // register writes and read notification from the serial front end
    input wire otalarm_pkg::reg_wr_t wr_i,
    input wire logic reg_read_i,
    // conversion start and result from the analogue side
    output logic conv_start_o,
    input wire otalarm_pkg::conv_res_t conv_i,
    // pec byte stream: clear at start, one pulse per byte
    input wire logic crc_clr_i,
    input wire logic crc_byte_vld_i,
    input wire logic [7:0] crc_byte_i,
    output logic [7:0] crc_o,
    output logic pec_en_o,
    // register contents
    output logic [15:0] cfg_o,
    output logic [15:0] temp_o,
    output logic [15:0] over_o,
    output logic [15:0] hyst_o,
    output logic [6:0] bus_addr_o,
    output logic busy_o
);
    import otalarm_pkg::*;

    // counter width; the slowest conversion and the longest slot must fit
    localparam int CW = 40;

    // refuse counts the logic cannot serve: tiny ones leave no room for the
    // resolution and rate shifts, huge ones overflow the counters
    if (CONV10_CYCLES < 8 || PERIOD4S_CYCLES < 2 * CONV10_CYCLES) begin : g_bad_timing
        $error("otalarm_pec: timing parameters too small");
    end
    if (PERIOD4S_CYCLES >= (longint'(1) << (CW - 3))) begin : g_bad_width
        $error("otalarm_pec: timing parameters overflow the counters");
    end

    // register state; the flag is kept apart from the writable bits
    logic [15:0] cfg_q;
    logic [14:0] cfg_lo_q;
    logic flag_q;
    logic [15:0] temp_q;
    logic [15:0] over_q;
    logic [15:0] hyst_q;
    logic [7:0] crc_q;
    logic [6:0] addr_q;

    // scheduler state
    logic [CW-1:0] conv_cnt_q;
    logic [CW-1:0] slot_cnt_q;
    logic [CW-1:0] conv_lim;
    logic [CW-1:0] slot_lim;
    logic conv_start_q;
    logic busy_q;
    logic oneshot_run_q;
    logic oneshot_late;
    conv_st_t st_q;

    // alarm state and comparisons
    logic [2:0] fault_q;
    logic [2:0] fq_need;
    arm_t arm_q;
    logic shdn_enter;
    logic shdn_eff;
    logic [15:0] hyst_eff;
    logic over_hit;
    logic below_hit;

    // ==========================================================
    // configuration, thresholds, address
    assign shdn_enter = wr_i.cfg_we && wr_i.wdata[B_SHDN] && !cfg_q[B_SHDN];

    // the visible word joins the writable bits with the alarm flag
    assign cfg_q = {flag_q, cfg_lo_q};

    // flag is owned by the alarm process, so mask it out here
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_lo_q <= CFG_POR[14:0];
        end else if (wr_i.cfg_we) begin
            cfg_lo_q <= wr_i.wdata[14:0] & CFG_WMASK[14:0];
        end else if (st_q == ST_CONV && oneshot_run_q && (conv_i.done || oneshot_late)) begin
            cfg_lo_q[B_ONESHOT] <= 1'b0;
        end
    end

    // thresholds take whole words; the front end merges single-byte writes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            over_q <= OVER_POR;
            hyst_q <= HYST_POR;
        end else begin
            if (wr_i.over_we)
                over_q <= wr_i.wdata;
            if (wr_i.hyst_we)
                hyst_q <= wr_i.wdata;
        end
    end

    // factory strap loaded by every clock edge, even during reset
    // the value never changes afterwards, so no reset branch is needed
    always_ff @(posedge clk_i) begin
        addr_q <= {ADDR_PREFIX, ADDR_SEL};
    end

    // ==========================================================
    // conversion scheduler
    // nominal conversion length and slot length from resolution and rate
    always_comb begin
        conv_lim = CONV10_CYCLES[CW-1:0] >> 2;
        unique case (cfg_q[B_RES_HI:B_RES_LO])
            2'b00: conv_lim = CONV10_CYCLES[CW-1:0] >> 2;
            2'b01: conv_lim = CONV10_CYCLES[CW-1:0] >> 1;
            2'b10: conv_lim = CONV10_CYCLES[CW-1:0];
            default: conv_lim = CONV10_CYCLES[CW-1:0] << 2;
        endcase
        slot_lim = PERIOD4S_CYCLES[CW-1:0];
        unique case (cfg_q[B_RATE_HI:B_RATE_LO])
            2'b00: slot_lim = PERIOD4S_CYCLES[CW-1:0];
            2'b01: slot_lim = PERIOD4S_CYCLES[CW-1:0] >> 2;
            2'b10: slot_lim = PERIOD4S_CYCLES[CW-1:0] >> 4;
            default: slot_lim = PERIOD4S_CYCLES[CW-1:0] >> 5;
        endcase
    end

    assign shdn_eff = cfg_q[B_SHDN];

    // a one-shot has no slot to end it, so twice the nominal length bounds it
    assign oneshot_late = oneshot_run_q && (conv_cnt_q + 1'b1 >= {conv_lim[CW-2:0], 1'b0});

    // conversions run to completion even if shutdown is requested meanwhile
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q <= ST_IDLE;
            conv_cnt_q <= '0;
            slot_cnt_q <= '0;
            conv_start_q <= 1'b0;
            busy_q <= 1'b0;
            oneshot_run_q <= 1'b0;
            temp_q <= 16'h0000;
        end else begin
            conv_start_q <= 1'b0;
            if (st_q != ST_IDLE)
                slot_cnt_q <= slot_cnt_q + 1'b1;
            case (st_q)
                ST_IDLE: begin
                    // free-running unless shut down; a one-shot runs even in shutdown
                    if (!shdn_eff || cfg_q[B_ONESHOT]) begin
                        st_q <= ST_CONV;
                        conv_start_q <= 1'b1;
                        busy_q <= 1'b1;
                        oneshot_run_q <= shdn_eff;
                        conv_cnt_q <= '0;
                        slot_cnt_q <= '0;
                    end
                end
                ST_CONV: begin
                    conv_cnt_q <= conv_cnt_q + 1'b1;
                    if (conv_i.done) begin
                        temp_q <= conv_i.value;
                        busy_q <= 1'b0;
                        st_q <= (shdn_eff) ? ST_IDLE : ST_WAIT;
                    end else if (!oneshot_run_q && slot_cnt_q + 1'b1 >= slot_lim) begin
                        // overrun: drop the result, keep the old temperature
                        busy_q <= 1'b0;
                        st_q <= ST_WAIT;
                    end else if (oneshot_late) begin
                        // a lost answer must not hang a one-shot forever
                        busy_q <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    // wait out the slot, or park at once when shut down
                    if (shdn_eff) begin
                        st_q <= ST_IDLE;
                    end else if (slot_cnt_q + 1'b1 >= slot_lim) begin
                        st_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // alarm comparison and flag
    // thresholds and results are two's complement words
    assign hyst_eff = ($signed(hyst_q) > $signed(over_q)) ? over_q : hyst_q;
    assign over_hit = $signed(conv_i.value) > $signed(over_q);
    assign below_hit = $signed(conv_i.value) < $signed(hyst_eff);

    // consecutive over-limit results needed before the flag may set
    always_comb begin
        unique case (cfg_q[B_FQ_HI:B_FQ_LO])
            2'b00: fq_need = FQ_N0;
            2'b01: fq_need = FQ_N1;
            2'b10: fq_need = FQ_N2;
            default: fq_need = FQ_N3;
        endcase
    end

    // one evaluation per accepted result; clear paths ignore the queue
    // a result and a read in one cycle: a set wins and the read is lost
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flag_q <= CFG_POR[B_FLAG];
            fault_q <= 3'h0;
            arm_q <= ARM_ABOVE;
        end else if (shdn_enter) begin
            // shutdown entry drops the flag and rearms, in either mode
            flag_q <= 1'b0;
            fault_q <= 3'h0;
            arm_q <= ARM_ABOVE;
        end else if (st_q == ST_CONV && conv_i.done) begin
            if (over_hit)
                fault_q <= (fault_q < fq_need) ? fault_q + 3'h1 : fault_q;
            else
                fault_q <= 3'h0;
            if (!cfg_q[B_MODE]) begin
                if (over_hit && fault_q + 3'h1 >= fq_need)
                    flag_q <= 1'b1;
                else if (below_hit)
                    flag_q <= 1'b0;
            end else if (arm_q == ARM_ABOVE && over_hit && fault_q + 3'h1 >= fq_need) begin
                flag_q <= 1'b1;
                arm_q <= ARM_BELOW;
            end else if (arm_q == ARM_BELOW && below_hit) begin
                flag_q <= 1'b1;
                arm_q <= ARM_ABOVE;
            end else if (reg_read_i) begin
                flag_q <= 1'b0;
            end
        end else if (reg_read_i && cfg_q[B_MODE]) begin
            // a mode write leaves the flag alone; a read or shutdown entry clears it
            flag_q <= 1'b0;
        end
    end

    // ==========================================================
    // pec crc-8, msb first over every byte including address
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++)
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        return r;
    endfunction

    // device side drives this on reads; front end feeds received bytes on writes
    // a clear and a byte in one cycle: the clear wins, the byte is dropped
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            crc_q <= 8'h00;
        else if (crc_clr_i)
            crc_q <= 8'h00;
        else if (crc_byte_vld_i)
            crc_q <= crc_step(crc_q, crc_byte_i);
    end

    // ==========================================================
    // outputs, each straight from its register
    // the config word carries the flag in its top bit
    assign cfg_o = cfg_q;
    assign temp_o = temp_q;
    assign over_o = over_q;
    assign hyst_o = hyst_q;
    // pec engine and bus identity
    assign crc_o = crc_q;
    assign pec_en_o = cfg_q[B_PEC];
    assign bus_addr_o = addr_q;
    // scheduler handshake
    assign conv_start_o = conv_start_q;
    assign busy_o = busy_q;
endmodule

// >>> dv/otalarm_assertions.sv
// concurrent checks on the alarm block ports
`timescale 1ns/1ps
module otalarm_assertions (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // stimulus side
    input wire otalarm_pkg::reg_wr_t wr_i,
    input wire logic reg_read_i,
    input wire otalarm_pkg::conv_res_t conv_i,
    input wire logic crc_clr_i,
    input wire logic crc_byte_vld_i,
    // observed outputs
    input wire logic [7:0] crc_o,
    input wire logic pec_en_o,
    input wire logic [15:0] cfg_o,
    input wire logic [15:0] over_o,
    input wire logic [15:0] hyst_o
);
    import otalarm_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // ==========================================================
    // result events; a config write in the same cycle may move the mode
    sequence hot_s;
        conv_i.done && !wr_i.cfg_we && $signed(conv_i.value) > $signed(over_o);
    endsequence
    sequence cold_s;
        conv_i.done && !wr_i.cfg_we && $signed(conv_i.value) < $signed(over_o) &&
            $signed(conv_i.value) < $signed(hyst_o);
    endsequence
    // ==========================================================
    // flag behaviour
    cmp_set_a: assert property (hot_s ##0 (!cfg_o[B_MODE] && cfg_o[12:11] == 2'b00)
        |=> cfg_o[B_FLAG]) else $error("flag not set after hot result");
    cmp_clear_a: assert property (cold_s ##0 !cfg_o[B_MODE] |=> !cfg_o[B_FLAG])
        else $error("flag not cleared after cold result");
    int_read_a: assert property (reg_read_i && cfg_o[B_MODE] && !conv_i.done &&
        !wr_i.cfg_we |=> !cfg_o[B_FLAG]) else $error("read did not clear flag");
    shdn_clear_a: assert property (wr_i.cfg_we && wr_i.wdata[B_SHDN] && !cfg_o[B_SHDN] &&
        !conv_i.done |=> !cfg_o[B_FLAG]) else $error("shutdown did not clear flag");
    flag_ro_a: assert property (wr_i.cfg_we && !cfg_o[B_FLAG] && !conv_i.done
        |=> !cfg_o[B_FLAG]) else $error("config write set the flag");
    // ==========================================================
    // register writes and pec
    cfg_write_a: assert property (wr_i.cfg_we |=> (cfg_o & 16'h7EFE) ==
        ($past(wr_i.wdata) & 16'h1AFE)) else $error("config write mismatch");
    over_write_a: assert property (wr_i.over_we |=> over_o == $past(wr_i.wdata))
        else $error("over threshold write mismatch");
    hyst_write_a: assert property (wr_i.hyst_we |=> hyst_o == $past(wr_i.wdata))
        else $error("hysteresis write mismatch");
    pec_level_a: assert property (wr_i.cfg_we |=>
        pec_en_o == $past(wr_i.wdata[B_PEC])) else $error("pec enable differs from config");
    crc_clear_a: assert property (crc_clr_i && !crc_byte_vld_i |=> crc_o == 8'h00)
        else $error("crc not cleared");
endmodule
bind otalarm_pec otalarm_assertions chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .wr_i(wr_i),
    .reg_read_i(reg_read_i), .conv_i(conv_i), .crc_clr_i(crc_clr_i),
    .crc_byte_vld_i(crc_byte_vld_i), .crc_o(crc_o), .pec_en_o(pec_en_o), .cfg_o(cfg_o),
    .over_o(over_o), .hyst_o(hyst_o));

// >>> dv/adc_model.sv
// analogue converter stand-in answering conversion starts
`timescale 1ns/1ps
module adc_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // request and settings
    input wire logic start_i,
    input wire logic [15:0] temp_i,
    input wire logic [9:0] dly_i,
    // result toward the alarm block
    output otalarm_pkg::conv_res_t conv_o
);
    logic [9:0] cnt_q;
    logic run_q;
    // one result per start; a new start restarts the count
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_q <= 1'b0;
            cnt_q <= '0;
            conv_o <= '0;
        end else begin
            conv_o.done <= run_q && cnt_q == 10'h001 && !start_i;
            // value toggles outside a result so stale data never looks valid
            conv_o.value <= (run_q && cnt_q == 10'h001) ? temp_i : ~conv_o.value;
            if (start_i) begin
                run_q <= 1'b1;
                cnt_q <= dly_i;
            end else if (run_q) begin
                cnt_q <= cnt_q - 10'h001;
                run_q <= cnt_q != 10'h001;
            end
        end
    end
endmodule

// >>> dv/testbench.sv
// self-checking bench for the alarm and pec block
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin checks++; if ((ac) !== (ex)) begin fails++; \
    $display("unexpected %s exp %h got %h", nm, ex, ac); end end
module testbench;
    import otalarm_pkg::*;
    logic clk_i, arst_n_i, rd, crc_clr, crc_vld, start, pec_en, busy;
    logic [15:0] cfg, temp_o, over, hyst, temp;
    logic [7:0] crc_b, crc, e;
    logic [6:0] addr;
    logic [9:0] dly;
    reg_wr_t wr;
    conv_res_t conv;
    int fails, checks;
    int nf[4] = '{1, 2, 4, 6};
    logic [7:0] msg[3] = '{8'h9A, 8'h01, 8'h5A};
    // ==========================================================
    // small counts keep conversions short
    otalarm_pec #(.CONV10_CYCLES(64), .PERIOD4S_CYCLES(1024), .ADDR_SEL(3'h5)) uut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .wr_i(wr), .reg_read_i(rd), .conv_start_o(start),
        .conv_i(conv), .crc_clr_i(crc_clr), .crc_byte_vld_i(crc_vld), .crc_byte_i(crc_b),
        .crc_o(crc), .pec_en_o(pec_en), .cfg_o(cfg), .temp_o(temp_o), .over_o(over),
        .hyst_o(hyst), .bus_addr_o(addr), .busy_o(busy));
    adc_model adc (.clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(start), .temp_i(temp),
        .dly_i(dly), .conv_o(conv));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // ==========================================================
    // access tasks
    task automatic final_report;
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // we bits: config, over, hysteresis
    task automatic wreg(input logic [2:0] we, input logic [15:0] v);
        wr <= {we, v};
        @(posedge clk_i);
        wr <= '0;
        @(posedge clk_i);
    endtask
    task automatic rdp;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        @(posedge clk_i);
    endtask
    // skip one edge so a result already in flight is not taken for the new one
    task automatic cv(input logic [15:0] t);
        temp <= t;
        @(posedge clk_i);
        for (int i = 0; i <= 3000; i++) begin
            @(posedge clk_i);
            if (conv.done) begin
                `CHK("busy", 1'b1, busy)
                break;
            end
            if (i == 3000) begin
                fails++;
                final_report();
            end
        end
        @(posedge clk_i);
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        repeat (8) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
        return r;
    endfunction
    // ==========================================================
    // scenarios
    initial begin
        fails = 0;
        checks = 0;
        arst_n_i = 1'b0;
        {rd, crc_clr, crc_vld, crc_b, wr} = '0;
        temp = 16'h1900;
        dly = 10'd8;
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        `CHK("cfg", 16'h0040, cfg)
        `CHK("over", 16'h5000, over)
        `CHK("hyst", 16'h4B00, hyst)
        wreg(3'b100, 16'hFFFF);
        `CHK("reserved", 16'h0000, cfg & 16'hE400)
        wreg(3'b100, 16'h0042);
        wreg(3'b010, 16'h5000);
        cv(16'h5100);
        `CHK("flag", 1'b1, cfg[15])
        `CHK("temp", 16'h5100, temp_o)
        rdp();
        cv(16'h4C00);
        `CHK("flag", 1'b1, cfg[15])
        cv(16'h4A00);
        `CHK("flag", 1'b0, cfg[15])
        for (int k = 0; k < 4; k++) begin
            wreg(3'b100, 16'h0042 | (16'(k) << 11));
            cv(16'h4A00);
            for (int j = 1; j < nf[k]; j++) begin
                cv(16'h5100);
                `CHK("queue", 1'b0, cfg[15])
            end
            cv(16'h5100);
            `CHK("queue", 1'b1, cfg[15])
        end
        cv(16'h4A00);
        wreg(3'b100, 16'h0242);
        cv(16'h5100);
        `CHK("int", 1'b1, cfg[15])
        rdp();
        `CHK("int", 1'b0, cfg[15])
        cv(16'h5100);
        `CHK("int", 1'b0, cfg[15])
        cv(16'h4A00);
        `CHK("int", 1'b1, cfg[15])
        rdp();
        cv(16'h5100);
        `CHK("int", 1'b1, cfg[15])
        wreg(3'b100, 16'h0042);
        `CHK("mode", 1'b1, cfg[15])
        wreg(3'b100, 16'h0342);
        `CHK("shdn", 1'b0, cfg[15])
        wreg(3'b001, 16'h6000);
        wreg(3'b100, 16'h0042);
        cv(16'h5100);
        // exactly at the limit: only the clamped hysteresis keeps the flag
        cv(16'h5000);
        `CHK("clamp", 1'b1, cfg[15])
        cv(16'h4F00);
        `CHK("hyst", 1'b0, cfg[15])
        wreg(3'b100, 16'h004A);
        `CHK("pec", 1'b1, pec_en)
        `CHK("addr", 7'h4D, addr)
        crc_clr <= 1'b1;
        e = 8'h00;
        @(posedge clk_i);
        crc_clr <= 1'b0;
        // back to back bytes, address byte first
        for (int i = 0; i < 3; i++) begin
            crc_vld <= 1'b1;
            crc_b <= msg[i];
            e = crc8(e, msg[i]);
            @(posedge clk_i);
        end
        crc_vld <= 1'b0;
        @(posedge clk_i);
        `CHK("crc", e, crc)
        // slow answers overrun the shortest slot at full resolution
        dly <= 10'd100;
        temp <= 16'h5500;
        wreg(3'b100, 16'h0066);
        repeat (400) @(posedge clk_i);
        `CHK("keep", 16'h4F00, temp_o)
        final_report();
    end
endmodule
